// *** rtl/sirqa_agent.sv ***
// serialized interrupt slave agent: reports interrupt line levels in time slots on a shared wire
// assumes a host controller on the same clock and an external pull-up that resolves the wire
//
// How it works
// - quiet idle bus: request a cycle by one low clock, then release, never high
// - never start a frame while a cycle runs; idle only between stop and start
// - quiet mode: any undelivered line change makes the agent request a start frame
// - continuous mode: only the host starts cycles, the agent stays passive
// - the mode changes only at a stop frame, never mid cycle
// - after reset the mode is continuous, so the agent never requests first
// - measure every stop pulse low width to choose the next cycle's mode
// - find the start pulse rising edge and count data frames from it
// - each data frame is sample, recovery, turn-around, one clock each
// - in own sample phase drive low only if captured level is low
// - in recovery drive high one clock exactly when low was driven before
// - release the wire in every turn-around phase
// - drive the slots in every cycle, whoever started it
// - slot n sample falls 3n-1 clocks after the start rising edge
// - enable bit 6 gates management interrupt into slot, bit 7 onto its pin
// - slot 14 carries interrupt 13; every function can select interrupt 13
// - two clock stop selects quiet; requests allowed from second clock after rise
// - three clock stop selects continuous; no requests after it
// - drive and sample the wire only on the rising clock edge
// - wire released during reset; reset enters continuous idle
`timescale 1ns/1ps
`include "sirqa_defines.svh"

module sirqa_agent (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      serirq_i,
   output logic                           serirq_o,
   output logic                           serirq_oe_n_o,
   input  wire logic [`SIRQA_NUM_DEV-1:0] dev_req_i,
   input  wire sirqa_pkg::sirqa_route_s   route_i,
   input  wire logic                      mgmt_interrupt_n_i,
   input  wire logic [7:0]                mgmt_enable_i,
   output logic                           mgmt_interrupt_out_n_o,
   output logic                           quiet_mode_o,
   output logic                           cycle_active_o
);

   sirqa_pkg::sirqa_st_s        st_reg;
   sirqa_pkg::sirqa_st_s        st_next;
   logic [`SIRQA_SYNC_W-1:0]    sync_q;
   logic                        bus_s;
   logic                        smi_s;
   logic [`SIRQA_NUM_DEV-1:0]   req_s;
   logic                        smi_gate;
   logic [`SIRQA_NUM_LINES-1:0] lvl;
   logic                        pending;
   logic                        rise;

   // pin and interrupt lines pass two flops
   sirqa_sync u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({dev_req_i, mgmt_interrupt_n_i, serirq_i}),
      .q_o     (sync_q)
   );

   assign bus_s    = sync_q[`SIRQA_SYNC_PIN];
   assign smi_s    = sync_q[`SIRQA_SYNC_SMI];
   assign req_s    = sync_q[`SIRQA_SYNC_REQ_HI:`SIRQA_SYNC_REQ_LO];
   assign smi_gate = mgmt_enable_i[`SIRQA_EN_SERIAL_BIT] ? smi_s : 1'b1;

   // line k, 1 to 15, is low while any function routed to k requests; line 0 stays high
   assign lvl[0] = 1'b1;
   for (genvar k = 1; k < `SIRQA_NUM_LINES; k++) begin : g_line
      logic [`SIRQA_NUM_DEV-1:0] hit;
      for (genvar d = 0; d < `SIRQA_NUM_DEV; d++) begin : g_dev
         assign hit[d] = req_s[d] & (route_i.sel[d] == `SIRQA_SEL_W'(k));
      end
      if (k == `SIRQA_SMI_LINE) begin : g_smi
         assign lvl[k] = ~(|hit) & smi_gate;
      end else begin : g_irq
         assign lvl[k] = ~(|hit);
      end
   end

   // a change is pending until its slot has carried the new level
   assign pending = |((lvl ^ st_reg.sent) & `SIRQA_LINE_MASK);
   assign rise    = bus_s & ~st_reg.prev;

   always_comb begin
      logic [4:0] slot_n;
      logic [3:0] idx;
      st_next         = st_reg;
      slot_n          = (st_reg.slot == `SIRQA_SLOT_MAX) ? st_reg.slot : st_reg.slot + 5'h01;
      idx             = 4'(slot_n - 5'h01);
      st_next.prev    = bus_s;
      st_next.low_run = bus_s ? 2'h0 :
                        (st_reg.low_run == `SIRQA_RUN_MAX) ? st_reg.low_run : st_reg.low_run + 2'h1;
      st_next.oe_n    = 1'b1;
      st_next.out     = 1'b1;
      st_next.mgmt_n  = mgmt_enable_i[`SIRQA_EN_PIN_BIT] ? smi_s : 1'b1;
      unique case (st_reg.state)
         sirqa_pkg::ST_IDLE: begin
            if (!bus_s) begin
               st_next.state = sirqa_pkg::ST_START;
            end else if (st_reg.quiet && pending && st_reg.prev) begin
               st_next.state = sirqa_pkg::ST_REQ;
               st_next.oe_n  = 1'b0;
               st_next.out   = 1'b0;
            end
         end
         sirqa_pkg::ST_REQ: begin
            st_next.state = sirqa_pkg::ST_START;
         end
         sirqa_pkg::ST_START: begin
            if (rise) begin
               st_next.state     = sirqa_pkg::ST_ACTIVE;
               st_next.ph        = sirqa_pkg::PH_REC;
               st_next.slot      = `SIRQA_SLOT_INIT;
               st_next.drove_low = 1'b0;
            end
         end
         sirqa_pkg::ST_ACTIVE: begin
            if (rise && (st_reg.low_run >= `SIRQA_STOP_MIN)) begin
               st_next.state     = sirqa_pkg::ST_IDLE;
               st_next.quiet     = (st_reg.low_run == `SIRQA_STOP_QUIET);
               st_next.drove_low = 1'b0;
            end else begin
               unique case (st_reg.ph)
                  sirqa_pkg::PH_SAMPLE: begin
                     st_next.ph = sirqa_pkg::PH_REC;
                     if (st_reg.drove_low) begin
                        st_next.oe_n = 1'b0;
                        st_next.out  = 1'b1;
                     end
                  end
                  sirqa_pkg::PH_REC: begin
                     st_next.ph        = sirqa_pkg::PH_TA;
                     st_next.drove_low = 1'b0;
                  end
                  sirqa_pkg::PH_TA: begin
                     st_next.ph   = sirqa_pkg::PH_SAMPLE;
                     st_next.slot = slot_n;
                     if ((slot_n >= `SIRQA_SLOT_FIRST) && (slot_n <= `SIRQA_SLOT_LAST)) begin
                        st_next.sent[idx] = lvl[idx];
                        if (!lvl[idx]) begin
                           st_next.oe_n      = 1'b0;
                           st_next.out       = 1'b0;
                           st_next.drove_low = 1'b1;
                        end
                     end
                  end
                  default: begin
                     st_next.ph = sirqa_pkg::PH_SAMPLE;
                  end
               endcase
            end
         end
      endcase
      st_next.busy = (st_next.state != sirqa_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg.state     <= sirqa_pkg::ST_IDLE;
         st_reg.ph        <= sirqa_pkg::PH_SAMPLE;
         st_reg.slot      <= `SIRQA_SLOT_INIT;
         st_reg.low_run   <= 2'h0;
         st_reg.prev      <= 1'b1;
         st_reg.quiet     <= 1'b0;
         st_reg.drove_low <= 1'b0;
         st_reg.sent      <= `SIRQA_SENT_RST;
         st_reg.oe_n      <= 1'b1;
         st_reg.out       <= 1'b1;
         st_reg.mgmt_n    <= 1'b1;
         st_reg.busy      <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign serirq_o               = st_reg.out;
   assign serirq_oe_n_o          = st_reg.oe_n;
   assign mgmt_interrupt_out_n_o = st_reg.mgmt_n;
   assign quiet_mode_o           = st_reg.quiet;
   assign cycle_active_o         = st_reg.busy;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_req_one_clock;
      (st_reg.state == sirqa_pkg::ST_REQ) |-> !st_reg.oe_n && !st_reg.out ##1 st_reg.oe_n;
   endproperty
   a_req_one_clock: assert property (p_req_one_clock)
      else $error("start request not exactly one low clock");

   property p_req_only_idle;
      (st_reg.state == sirqa_pkg::ST_REQ) |-> $past(st_reg.state) == sirqa_pkg::ST_IDLE && $past(bus_s);
   endproperty
   a_req_only_idle: assert property (p_req_only_idle)
      else $error("start request outside idle bus");

   property p_req_only_quiet;
      (st_reg.state == sirqa_pkg::ST_REQ) |-> $past(st_reg.quiet);
   endproperty
   a_req_only_quiet: assert property (p_req_only_quiet)
      else $error("start request in continuous mode");

   property p_pending_requests;
      (st_reg.state == sirqa_pkg::ST_IDLE && st_reg.quiet && pending && bus_s && st_reg.prev)
         |=> st_reg.state == sirqa_pkg::ST_REQ;
   endproperty
   a_pending_requests: assert property (p_pending_requests)
      else $error("pending change without start request");

   property p_mode_at_stop;
      $changed(st_reg.quiet) |-> st_reg.state == sirqa_pkg::ST_IDLE && $past(st_reg.state) == sirqa_pkg::ST_ACTIVE;
   endproperty
   a_mode_at_stop: assert property (p_mode_at_stop)
      else $error("mode changed outside a stop frame");

   property p_stop_width;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && rise && st_reg.low_run >= `SIRQA_STOP_MIN)
         |=> st_reg.quiet == ($past(st_reg.low_run) == `SIRQA_STOP_QUIET);
   endproperty
   a_stop_width: assert property (p_stop_width)
      else $error("stop width decoded to wrong mode");

   property p_frame_order;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_SAMPLE && !rise)
         |=> (st_reg.ph == sirqa_pkg::PH_REC || st_reg.state != sirqa_pkg::ST_ACTIVE)
         ##1 (st_reg.ph == sirqa_pkg::PH_TA || st_reg.state != sirqa_pkg::ST_ACTIVE);
   endproperty
   a_frame_order: assert property (p_frame_order)
      else $error("data frame phases out of order");

   property p_low_only_sample;
      (!st_reg.oe_n && !st_reg.out && st_reg.state == sirqa_pkg::ST_ACTIVE)
         |-> st_reg.ph == sirqa_pkg::PH_SAMPLE && st_reg.slot >= `SIRQA_SLOT_FIRST && st_reg.slot <= `SIRQA_SLOT_LAST;
   endproperty
   a_low_only_sample: assert property (p_low_only_sample)
      else $error("low driven outside an own sample phase");

   property p_recovery_high;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_SAMPLE && !st_reg.oe_n && !rise)
         |=> !st_reg.oe_n && st_reg.out ##1 st_reg.oe_n;
   endproperty
   a_recovery_high: assert property (p_recovery_high)
      else $error("recovery high drive missing or too long");

   property p_high_only_recovery;
      (!st_reg.oe_n && st_reg.out) |-> st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_REC;
   endproperty
   a_high_only_recovery: assert property (p_high_only_recovery)
      else $error("high driven outside recovery");

   property p_ta_released;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_TA) |-> st_reg.oe_n;
   endproperty
   a_ta_released: assert property (p_ta_released)
      else $error("wire driven in turn-around");

   property p_slot_timing;
      (st_reg.state == sirqa_pkg::ST_START && rise)
         |=> ##2 (st_reg.slot == 5'h02 && st_reg.ph == sirqa_pkg::PH_SAMPLE || st_reg.state != sirqa_pkg::ST_ACTIVE);
   endproperty
   a_slot_timing: assert property (p_slot_timing)
      else $error("slot 2 sample not five clocks after start edge");

   property p_mgmt_pin;
      !mgmt_enable_i[`SIRQA_EN_PIN_BIT] ##1 !mgmt_enable_i[`SIRQA_EN_PIN_BIT] |-> mgmt_interrupt_out_n_o;
   endproperty
   a_mgmt_pin: assert property (p_mgmt_pin)
      else $error("management pin active while disabled");

   property p_mgmt_pin_follows;
      mgmt_enable_i[`SIRQA_EN_PIN_BIT] |=> mgmt_interrupt_out_n_o == $past(smi_s);
   endproperty
   a_mgmt_pin_follows: assert property (p_mgmt_pin_follows)
      else $error("management pin does not follow the captured interrupt");

   property p_start_edge;
      (st_reg.state == sirqa_pkg::ST_START && rise)
         |=> st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_REC
             && st_reg.slot == `SIRQA_SLOT_INIT;
   endproperty
   a_start_edge: assert property (p_start_edge)
      else $error("frame count not started at the start pulse edge");

   property p_slot_step;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_TA && st_reg.slot != `SIRQA_SLOT_MAX)
         |=> st_reg.slot == $past(st_reg.slot) + 5'h01 || st_reg.state != sirqa_pkg::ST_ACTIVE;
   endproperty
   a_slot_step: assert property (p_slot_step)
      else $error("slot count did not advance after turn-around");

   property p_sample_level;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_SAMPLE
         && st_reg.slot >= `SIRQA_SLOT_FIRST && st_reg.slot <= `SIRQA_SLOT_LAST)
         |-> st_reg.oe_n == st_reg.sent[4'(st_reg.slot - 5'h01)];
   endproperty
   a_sample_level: assert property (p_sample_level)
      else $error("sample drive differs from the captured level");

   property p_recovery_after_low;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && st_reg.ph == sirqa_pkg::PH_REC && !st_reg.oe_n)
         |-> $past(st_reg.oe_n) == 1'b0 && $past(st_reg.out) == 1'b0;
   endproperty
   a_recovery_after_low: assert property (p_recovery_after_low)
      else $error("recovery drive without a low sample before it");

   property p_bus_released;
      (st_reg.state == sirqa_pkg::ST_IDLE || st_reg.state == sirqa_pkg::ST_START) |-> st_reg.oe_n;
   endproperty
   a_bus_released: assert property (p_bus_released)
      else $error("wire driven outside a request or a cycle");

   property p_start_joined;
      (st_reg.state == sirqa_pkg::ST_IDLE && !bus_s) |=> st_reg.state == sirqa_pkg::ST_START;
   endproperty
   a_start_joined: assert property (p_start_joined)
      else $error("start frame of another agent not followed");

   property p_continuous_passive;
      (st_reg.state == sirqa_pkg::ST_IDLE && !st_reg.quiet) |=> st_reg.state != sirqa_pkg::ST_REQ;
   endproperty
   a_continuous_passive: assert property (p_continuous_passive)
      else $error("start request while the host owns the bus");

   property p_stop_to_idle;
      (st_reg.state == sirqa_pkg::ST_ACTIVE && rise && st_reg.low_run >= `SIRQA_STOP_MIN)
         |=> st_reg.state == sirqa_pkg::ST_IDLE;
   endproperty
   a_stop_to_idle: assert property (p_stop_to_idle)
      else $error("cycle not ended by the stop frame");

   c_quiet_request: cover property (st_reg.state == sirqa_pkg::ST_REQ);
   c_host_start:    cover property (st_reg.state == sirqa_pkg::ST_IDLE && !bus_s);
   c_slot_driven:   cover property (!st_reg.oe_n && !st_reg.out && st_reg.state == sirqa_pkg::ST_ACTIVE);
   c_to_quiet:      cover property ($rose(st_reg.quiet));
   c_to_cont:       cover property ($fell(st_reg.quiet));

endmodule

// *** rtl/sirqa_defines.svh ***
// constants of the serialized interrupt slave agent
// assumes inclusion by the agent package and modules only
`ifndef SIRQA_DEFINES_SVH
`define SIRQA_DEFINES_SVH

// synchroniser: {device requests[4:0], management interrupt (low active), bus pin}
`define SIRQA_SYNC_W        7
`define SIRQA_SYNC_RST      7'h03
`define SIRQA_SYNC_PIN      0
`define SIRQA_SYNC_SMI      1
`define SIRQA_SYNC_REQ_LO   2
`define SIRQA_SYNC_REQ_HI   6

// interrupt routing
`define SIRQA_NUM_DEV       5
`define SIRQA_NUM_LINES     16
`define SIRQA_SEL_W         4

// slot numbering: slot n carries line n-1
`define SIRQA_SLOT_INIT     5'h01
`define SIRQA_SLOT_FIRST    5'h02
`define SIRQA_SLOT_LAST     5'h10
`define SIRQA_SLOT_MAX      5'h1F
`define SIRQA_SMI_LINE      2
`define SIRQA_LINE_MASK     16'hFFFE

// management enable register bit positions
`define SIRQA_EN_SERIAL_BIT 6
`define SIRQA_EN_PIN_BIT    7

// stop pulse widths in clocks
`define SIRQA_STOP_QUIET    2'h2
`define SIRQA_STOP_MIN      2'h2
`define SIRQA_RUN_MAX       2'h3

// reset values
`define SIRQA_SENT_RST      16'hFFFF

`endif

// *** rtl/sirqa_pkg.sv ***
// types of the serialized interrupt slave agent
// assumes the defines header is on the include path
package sirqa_pkg;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_REQ    = 2'b01,
      ST_START  = 2'b10,
      ST_ACTIVE = 2'b11
   } sirqa_state_e;

   typedef enum logic [1:0] {
      PH_SAMPLE = 2'b00,
      PH_REC    = 2'b01,
      PH_TA     = 2'b10
   } sirqa_phase_e;

   // interrupt number selected per function: 0 fdc, 1 parallel, 2 serial 1, 3 serial 2, 4 keyboard
   typedef struct packed {
      logic [4:0][3:0] sel;
   } sirqa_route_s;

   typedef struct packed {
      logic [6:0] ff1;
      logic [6:0] ff2;
   } sirqa_sync_s;

   typedef struct packed {
      sirqa_state_e state;
      sirqa_phase_e ph;
      logic [4:0]   slot;
      logic [1:0]   low_run;
      logic         prev;
      logic         quiet;
      logic         drove_low;
      logic [15:0]  sent;
      logic         oe_n;
      logic         out;
      logic         mgmt_n;
      logic         busy;
   } sirqa_st_s;

endpackage

// *** rtl/sirqa_sync.sv ***
// two-stage synchroniser for the agent's pin and interrupt inputs
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps
`include "sirqa_defines.svh"

module sirqa_sync (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic [`SIRQA_SYNC_W-1:0] d_i,
   output logic      [`SIRQA_SYNC_W-1:0] q_o
);

   sirqa_pkg::sirqa_sync_s st_reg;
   sirqa_pkg::sirqa_sync_s st_next;

   always_comb begin
      st_next     = st_reg;
      st_next.ff1 = d_i;
      st_next.ff2 = st_reg.ff1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg.ff1 <= `SIRQA_SYNC_RST;
         st_reg.ff2 <= `SIRQA_SYNC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q_o = st_reg.ff2;

endmodule

// *** tb/sirqa_host_model.sv ***
// host controller model for the serialized interrupt wire
// assumes the bench resolves the wire with a pull-up and feeds it back on wire_i
`timescale 1ns/1ps

module sirqa_host_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       wire_i,
   input  wire logic       go_i,
   input  wire logic [2:0] ext_i,
   input  wire logic [1:0] stop_len_i,
   output logic            drv_o = 1'b0,
   output logic            val_o = 1'b1,
   output logic            edge_o = 1'b0,
   output logic            busy_o = 1'b0
);
   // drives the wire for n clocks, changing only at the rising edge
   task automatic drive(input logic v, input int n);
      for (int i = 0; i < n; i++) begin
         drv_o <= 1'b1;
         val_o <= v;
         @(posedge clk_i);
      end
   endtask

   // starts only while idle; a low seen while idle is an agent request to extend
   always begin
      @(posedge clk_i);
      if (rst_n_i && (go_i || !wire_i)) begin
         busy_o <= 1'b1;
         drive(1'b0, go_i ? int'(ext_i) + 1 : int'(ext_i));
         edge_o <= 1'b1;
         drive(1'b1, 1);
         edge_o <= 1'b0;
         drv_o  <= 1'b0;
         repeat (49) @(posedge clk_i);
         drive(1'b0, int'(stop_len_i));
         drive(1'b1, 1);
         drv_o  <= 1'b0;
         busy_o <= 1'b0;
      end
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench of the serialized interrupt slave agent
// assumes the agent package, header and host model are compiled first
`timescale 1ns/1ps

module tb_top;
   logic                    clk_i = 1'b0;
   logic                    rst_n_i = 1'b0;
   logic [4:0]              dev_req = 5'h00;
   sirqa_pkg::sirqa_route_s route = '0;
   logic                    mgmt_n = 1'b1;
   logic [7:0]              mgmt_en = 8'h00;
   logic                    go = 1'b0;
   logic [2:0]              ext = 3'h3;
   logic [1:0]              stop_len = 2'h3;
   logic                    agent_out, agent_oe_n, mgmt_out_n, quiet, active;
   logic                    h_drv, h_val, h_edge, h_busy, serirq;
   logic                    prev_req = 1'b0;
   logic [15:0]             low_snap = 16'h0000;
   logic [31:0]             rng = 32'h0000002F;
   logic [31:0]             rnd;
   int                      error_cnt = 0;
   int                      samples_checked = 0;
   int                      cyc = 0;
   int                      k = -1;
   int                      req_cnt = 0;

   assign serirq = h_drv ? h_val : (agent_oe_n ? 1'b1 : agent_out);

   always #20 clk_i = ~clk_i;

   sirqa_agent sirqa_agent_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .serirq_i(serirq), .serirq_o(agent_out),
      .serirq_oe_n_o(agent_oe_n), .dev_req_i(dev_req), .route_i(route), .mgmt_interrupt_n_i(mgmt_n),
      .mgmt_enable_i(mgmt_en), .mgmt_interrupt_out_n_o(mgmt_out_n), .quiet_mode_o(quiet),
      .cycle_active_o(active)
   );

   sirqa_host_model sirqa_host_model_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .wire_i(serirq), .go_i(go), .ext_i(ext),
      .stop_len_i(stop_len), .drv_o(h_drv), .val_o(h_val), .edge_o(h_edge), .busy_o(h_busy)
   );

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // reference line levels: a line other than 0 is low when any function routed to it requests
   function automatic logic [15:0] lines_low();
      logic [15:0] l;
      l = 16'h0000;
      for (int d = 0; d < 5; d++) if (dev_req[d]) l[route.sel[d]] = 1'b1;
      if (mgmt_en[6] && !mgmt_n) l[2] = 1'b1;
      l[0] = 1'b0;
      return l;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_busy(input logic v);
      for (int i = 0; i < 100 && h_busy !== v; i++) @(negedge clk_i);
      check(h_busy, v, "host wait");
   endtask

   task automatic host_cycle(input logic [2:0] e, input logic [1:0] s);
      ext = e;
      stop_len = s;
      go = 1'b1;
      wait_busy(1'b1);
      go = 1'b0;
      wait_busy(1'b0);
      repeat (4) @(negedge clk_i);
   endtask

   // frame monitor: clocks 1 to 49 after the start edge compared with the reference slot map
   always @(negedge clk_i) begin
      int  n;
      logic exp;
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         print_verdict();
      end
      if (h_edge) begin
         k = 0;
         low_snap = lines_low();
      end else if (k >= 0) k = (k < 49) ? k + 1 : -1;
      if (k >= 1) begin
         n = (k + 1) / 3;
         exp = (k % 3 != 1) && n >= 2 && n <= 16 && low_snap[n-1];
         check(agent_oe_n, !exp, "slot enable");
         check(agent_out, exp ? (k % 3 == 0) : 1'b1, "slot value");
         check(active, 1'b1, "cycle active");
      end
      if (prev_req) check(agent_oe_n, 1'b1, "request release");
      prev_req = 1'b0;
      if (!h_busy && k < 0 && agent_oe_n === 1'b0) begin
         req_cnt++;
         prev_req = 1'b1;
         check(agent_out, 1'b0, "request level");
      end
   end

   initial begin
      repeat (11) @(negedge clk_i);
      check({agent_oe_n, agent_out, quiet, active}, 8'h0C, "reset outputs");
      @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (6) begin
         rnd = xs();
         dev_req = rnd[4:0];
         route = rnd[24:5];
         repeat (5) @(negedge clk_i);
      end
      check(req_cnt, 0, "request after reset");
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         rnd = xs();
         route = rnd[19:0];
         route.sel[i] = 4'hD;
         dev_req = rnd[24:20] | (5'h01 << i);
         mgmt_n = rnd[25];
         mgmt_en = rnd[31:24];
         repeat (4) @(negedge clk_i);
         host_cycle(3'(3 + i), 2'h3);
         check(quiet, 1'b0, "continuous mode");
         check(mgmt_out_n, mgmt_en[7] ? mgmt_n : 1'b1, "mgmt pin");
      end
      check(req_cnt, 0, "request in continuous");
      $display("test host cycles done");
      route = '0;
      route.sel[0] = 4'h9;
      dev_req = 5'h00;
      repeat (4) @(negedge clk_i);
      host_cycle(3'h4, 2'h2);
      check(quiet, 1'b1, "quiet mode");
      stop_len = 2'h3;
      dev_req = 5'h01;
      wait_busy(1'b1);
      check(req_cnt, 1, "quiet request");
      wait_busy(1'b0);
      repeat (4) @(negedge clk_i);
      check(quiet, 1'b0, "back to continuous");
      dev_req = 5'h00;
      repeat (30) @(negedge clk_i);
      check(req_cnt, 1, "passive after long stop");
      $display("test quiet request done");
      rst_n_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check({agent_oe_n, agent_out, quiet, active}, 8'h0C, "second reset");
      rst_n_i = 1'b1;
      host_cycle(3'h7, 2'h3);
      $display("test second reset done");
      print_verdict();
   end
endmodule
